// ---- logic/uess_pkg.sv ----
/*
  Constants for the endpoint select and status command block.
  Assumes a command interface that presents one command byte per strobe and a
  data read strobe for the one-byte answer, all on clk_sys.
*/
package uess_pkg;
  localparam int          NUM_EP        = 10;
  localparam int          EPW           = 4;
  localparam int          PTRW          = 9;
  localparam logic [7:0]  CMD_SEL_FIRST = 8'h00;
  localparam logic [7:0]  CMD_SEL_LAST  = 8'h09;
  localparam logic [7:0]  CMD_CLR_FIRST = 8'h40;
  localparam logic [7:0]  CMD_CLR_LAST  = 8'h47;
  localparam int          BIT_OCC       = 0;
  localparam int          BIT_HALT      = 1;
  localparam int          BIT_SETUP     = 2;
  localparam int          BIT_OVWR      = 3;
  localparam int          BIT_NAK       = 4;
  localparam int          BIT_B1        = 5;
  localparam int          BIT_B2        = 6;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam logic [9:0]  EP_FLAG_RESET = 10'h000;
endpackage : uess_pkg

// ---- logic/uess_endpoint_select_status.sv ----
/*
  Select endpoint and select-with-clear command handling, with per-endpoint
  setup, overwrite and NAK flags. Assumes the packet engine gives one-cycle
  event pulses with the endpoint number, and buffer-full, stall, direction
  and buffering levels per physical endpoint, all on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module uess_endpoint_select_status
(
  input  wire logic                          clk_sys,
  input  wire logic                          reset_n,
  input  wire logic                          cmd_valid,
  input  wire logic [7:0]                    cmd_code,
  input  wire logic                          data_rd,
  output logic      [7:0]                    data_out,
  output logic                               data_out_valid,
  output logic      [uess_pkg::PTRW-1:0]     buf_ptr,
  output logic                               buf_ptr_load,
  output logic      [uess_pkg::NUM_EP-1:0]   ep_int_clear,
  input  wire logic [uess_pkg::NUM_EP*uess_pkg::PTRW-1:0] ep_buf_base,
  input  wire logic [uess_pkg::NUM_EP-1:0]   ep_is_in,
  input  wire logic [uess_pkg::NUM_EP-1:0]   ep_is_control,
  input  wire logic [uess_pkg::NUM_EP-1:0]   ep_double_buf,
  input  wire logic [uess_pkg::NUM_EP-1:0]   ep_halted,
  input  wire logic [uess_pkg::NUM_EP-1:0]   ep_buf1_full,
  input  wire logic [uess_pkg::NUM_EP-1:0]   ep_buf2_full,
  input  wire logic [uess_pkg::NUM_EP-1:0]   ep_nak_int_en,
  input  wire logic                          ev_ack_rx,
  input  wire logic                          ev_ack_rx_setup,
  input  wire logic                          ev_setup_overwrite,
  input  wire logic                          ev_nak_sent,
  input  wire logic                          ev_in_acked,
  input  wire logic [uess_pkg::EPW-1:0]      ev_ep
);

  typedef struct packed {
    logic [uess_pkg::NUM_EP-1:0] setup;
    logic [uess_pkg::NUM_EP-1:0] ovwr;
    logic [uess_pkg::NUM_EP-1:0] nak;
    logic [7:0]                  dout;
    logic                        dvalid;
    logic [uess_pkg::PTRW-1:0]   ptr;
    logic                        ptr_load;
    logic [uess_pkg::NUM_EP-1:0] iclr;
  } uess_state_t;

  uess_state_t st_q;
  uess_state_t st_d;

  logic                        is_sel;
  logic                        is_clr;
  logic [uess_pkg::EPW-1:0]    cmd_ep;
  logic [uess_pkg::NUM_EP-1:0] ev_hit;
  logic [uess_pkg::NUM_EP-1:0] clr_hit;
  logic [uess_pkg::NUM_EP-1:0] set_setup;
  logic [uess_pkg::NUM_EP-1:0] clr_setup;
  logic [uess_pkg::NUM_EP-1:0] set_ovwr;
  logic [uess_pkg::NUM_EP-1:0] set_nak;
  logic [uess_pkg::NUM_EP-1:0] clr_nak;
  logic [uess_pkg::NUM_EP-1:0] occ;
  logic [uess_pkg::NUM_EP-1:0] clr_flags;
  logic [7:0]                  status_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode.

  assign is_sel = (cmd_code >= uess_pkg::CMD_SEL_FIRST) && (cmd_code <= uess_pkg::CMD_SEL_LAST);
  assign is_clr = (cmd_code >= uess_pkg::CMD_CLR_FIRST) && (cmd_code <= uess_pkg::CMD_CLR_LAST);
  assign cmd_ep = cmd_code[uess_pkg::EPW-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Per-endpoint flags. A hardware event in the same cycle as a clear wins.

  genvar g;
  generate
    for (g = 0; g < uess_pkg::NUM_EP; g++)
    begin : g_ep
      assign ev_hit[g]    = (int'(ev_ep) == g);
      assign clr_hit[g]   = cmd_valid && is_clr && (int'(cmd_ep) == g);
      assign clr_flags[g] = clr_hit[g] && ep_is_control[g] && !ep_is_in[g];
      assign set_setup[g] = ev_hit[g] && ev_ack_rx && ev_ack_rx_setup;
      assign clr_setup[g] = (ev_hit[g] && ev_ack_rx && !ev_ack_rx_setup) || clr_flags[g];
      assign set_ovwr[g]  = ev_hit[g] && ev_setup_overwrite;
      assign set_nak[g]   = ev_hit[g] && ev_nak_sent && ep_nak_int_en[g];
      assign clr_nak[g]   = ev_hit[g] && ((ev_ack_rx && !ep_is_in[g]) || ev_in_acked);
      // Single-buffered endpoints ignore the second full flag for occupancy; bit 6 still reports it.
      assign occ[g] = !ep_double_buf[g] ? ep_buf1_full[g] :
                      ep_is_in[g] ? (ep_buf1_full[g] & ep_buf2_full[g]) :
                                    (ep_buf1_full[g] | ep_buf2_full[g]);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Status byte of the endpoint that the command names.

  always_comb
  begin
    status_byte                     = uess_pkg::STATUS_RESET;
    if (cmd_ep < uess_pkg::NUM_EP)
    begin
      status_byte[uess_pkg::BIT_OCC]   = occ[cmd_ep];
      status_byte[uess_pkg::BIT_HALT]  = ep_halted[cmd_ep];
      status_byte[uess_pkg::BIT_SETUP] = st_q.setup[cmd_ep];
      status_byte[uess_pkg::BIT_OVWR]  = st_q.ovwr[cmd_ep];
      status_byte[uess_pkg::BIT_NAK]   = st_q.nak[cmd_ep];
      status_byte[uess_pkg::BIT_B1]    = ep_buf1_full[cmd_ep];
      status_byte[uess_pkg::BIT_B2]    = ep_buf2_full[cmd_ep];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state. The status byte is captured at command time, so a read
  // returns what the endpoint looked like when it was selected.

  always_comb
  begin
    st_d          = st_q;
    st_d.ptr_load = 1'b0;
    st_d.iclr     = '0;
    st_d.setup    = (st_q.setup & ~clr_setup) | set_setup;
    st_d.ovwr     = (st_q.ovwr & ~clr_flags) | set_ovwr;
    st_d.nak      = (st_q.nak & ~clr_nak) | set_nak;
    if (data_rd)
    begin
      st_d.dvalid = 1'b0;
    end
    if (cmd_valid && (is_sel || is_clr) && (cmd_ep < uess_pkg::NUM_EP))
    begin
      st_d.ptr      = ep_buf_base[cmd_ep*uess_pkg::PTRW +: uess_pkg::PTRW];
      st_d.ptr_load = 1'b1;
      st_d.dout     = status_byte;
      st_d.dvalid   = 1'b1;
      if (is_clr)
      begin
        st_d.iclr[cmd_ep] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      st_q        <= '0;
      st_q.setup  <= uess_pkg::EP_FLAG_RESET;
      st_q.ovwr   <= uess_pkg::EP_FLAG_RESET;
      st_q.nak    <= uess_pkg::EP_FLAG_RESET;
      st_q.dout   <= uess_pkg::STATUS_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign data_out       = st_q.dout;
  assign data_out_valid = st_q.dvalid;
  assign buf_ptr        = st_q.ptr;
  assign buf_ptr_load   = st_q.ptr_load;
  assign ep_int_clear   = st_q.iclr;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_sel_cmd;
    cmd_valid && is_sel && (cmd_ep < uess_pkg::NUM_EP);
  endsequence

  sequence s_clr_cmd;
    cmd_valid && is_clr;
  endsequence

  // Event sequences exclude endpoint numbers outside the table, because an
  // idle event bus may carry any value on its endpoint lines.
  sequence s_ev_setup_ack;
    ev_ack_rx && ev_ack_rx_setup && (ev_ep < uess_pkg::NUM_EP);
  endsequence

  sequence s_ev_data_ack;
    ev_ack_rx && !ev_ack_rx_setup && (ev_ep < uess_pkg::NUM_EP);
  endsequence

  sequence s_ev_overwrite;
    ev_setup_overwrite && (ev_ep < uess_pkg::NUM_EP);
  endsequence

  sequence s_ev_nak_enabled;
    ev_nak_sent && (ev_ep < uess_pkg::NUM_EP) && ep_nak_int_en[ev_ep];
  endsequence

  sequence s_refused_cmd;
    cmd_valid && (cmd_code > uess_pkg::CMD_SEL_LAST)
      && ((cmd_code < uess_pkg::CMD_CLR_FIRST) || (cmd_code > uess_pkg::CMD_CLR_LAST));
  endsequence

  sequence s_read_only;
    data_rd && !cmd_valid;
  endsequence

  chk_sel_ptr_load: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_sel_cmd |=> buf_ptr_load
      && (buf_ptr == $past(ep_buf_base[cmd_ep*uess_pkg::PTRW +: uess_pkg::PTRW])))
    else $error("Buffer pointer not loaded after select.");

  chk_status_avail: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (s_sel_cmd or s_clr_cmd) |=> data_out_valid && (data_out == $past(status_byte)))
    else $error("Status byte not presented after select.");

  chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    data_out_valid |-> !data_out[7])
    else $error("Reserved status bit is not zero.");

  chk_halt_bit: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_sel_cmd |=> data_out[1] == $past(ep_halted[cmd_ep]))
    else $error("Halt bit does not match endpoint.");

  chk_occ_single: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (s_sel_cmd ##0 !ep_double_buf[cmd_ep]) |=> data_out[0] == $past(ep_buf1_full[cmd_ep]))
    else $error("Single-buffered occupancy wrong.");

  chk_occ_in_and: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (s_sel_cmd ##0 (ep_double_buf[cmd_ep] && ep_is_in[cmd_ep]))
    |=> data_out[0] == ($past(ep_buf1_full[cmd_ep]) && $past(ep_buf2_full[cmd_ep])))
    else $error("IN occupancy is not the AND of both buffers.");

  chk_int_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_clr_cmd |=> ep_int_clear[$past(cmd_ep)] && $onehot(ep_int_clear))
    else $error("Interrupt status clear not one-hot on the selected endpoint.");

  chk_int_clear_drop: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (s_clr_cmd ##1 !(cmd_valid && is_clr)) |=> (ep_int_clear == '0))
    else $error("Interrupt status clear held longer than one cycle.");

  chk_nak_gated: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (ev_nak_sent && (ev_ep < uess_pkg::NUM_EP) && !ep_nak_int_en[ev_ep] && !st_q.nak[ev_ep])
    |=> !st_q.nak[$past(ev_ep)])
    else $error("NAK flag set with interrupt-on-NAK disabled.");

  chk_nak_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (ev_in_acked && !ev_nak_sent && (ev_ep < uess_pkg::NUM_EP)) |=> !st_q.nak[$past(ev_ep)])
    else $error("NAK flag not cleared after IN acknowledge.");

  chk_setup_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (s_clr_cmd ##0 (ep_is_control[cmd_ep] && !ep_is_in[cmd_ep] && ev_ep != cmd_ep))
    |=> !st_q.setup[$past(cmd_ep)] && !st_q.ovwr[$past(cmd_ep)])
    else $error("Setup or overwrite flag survived select-with-clear.");

  chk_occ_out_or: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (s_sel_cmd ##0 (ep_double_buf[cmd_ep] && !ep_is_in[cmd_ep]))
    |=> data_out[uess_pkg::BIT_OCC]
        == ($past(ep_buf1_full[cmd_ep]) || $past(ep_buf2_full[cmd_ep])))
    else $error("OUT occupancy is not the OR of both buffers.");

  chk_buf_bits: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_sel_cmd |=> (data_out[uess_pkg::BIT_B1] == $past(ep_buf1_full[cmd_ep]))
               && (data_out[uess_pkg::BIT_B2] == $past(ep_buf2_full[cmd_ep])))
    else $error("Buffer full bits do not match the endpoint.");

  chk_setup_bit: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_sel_cmd |=> data_out[uess_pkg::BIT_SETUP] == $past(st_q.setup[cmd_ep]))
    else $error("Setup bit of the status byte does not match the flag.");

  chk_ovwr_nak_bits: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_sel_cmd |=> (data_out[uess_pkg::BIT_OVWR] == $past(st_q.ovwr[cmd_ep]))
               && (data_out[uess_pkg::BIT_NAK] == $past(st_q.nak[cmd_ep])))
    else $error("Overwrite or NAK bit of the status byte does not match the flag.");

  ////////////////////////////////////////////////////////////////////////////
  // Flag and hold checks.

  chk_setup_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_ev_setup_ack |=> st_q.setup[$past(ev_ep)])
    else $error("Setup flag not set after an acknowledged SETUP.");

  chk_setup_reload: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_ev_data_ack |=> !st_q.setup[$past(ev_ep)])
    else $error("Setup flag kept after an acknowledged data packet.");

  chk_ovwr_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_ev_overwrite |=> st_q.ovwr[$past(ev_ep)])
    else $error("Overwrite flag not set after a SETUP overwrite.");

  chk_nak_set: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_ev_nak_enabled |=> st_q.nak[$past(ev_ep)])
    else $error("NAK flag not set after a NAK with the NAK interrupt enabled.");

  chk_nak_out_clear: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (s_ev_data_ack ##0 (!ep_is_in[ev_ep] && !ev_nak_sent)) |=> !st_q.nak[$past(ev_ep)])
    else $error("NAK flag not cleared after an acknowledged OUT packet.");

  chk_refused_code: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_refused_cmd |=> !buf_ptr_load && (ep_int_clear == '0) && $stable(data_out))
    else $error("Refused command code had an effect.");

  chk_rd_drops_valid: assert property (@(posedge clk_sys) disable iff (!reset_n)
    s_read_only |=> !data_out_valid)
    else $error("Status byte still valid after its read.");

  chk_data_held: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (data_out_valid && !data_rd && !cmd_valid) |=> data_out_valid && $stable(data_out))
    else $error("Status byte changed before it was read.");

  chk_ptr_held: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !cmd_valid |=> $stable(buf_ptr) && !buf_ptr_load)
    else $error("Buffer pointer moved without a select command.");

  chk_flags_kept: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (s_clr_cmd ##0 (!(ep_is_control[cmd_ep] && !ep_is_in[cmd_ep]) && (ev_ep != cmd_ep)))
    |=> (st_q.setup[$past(cmd_ep)] == $past(st_q.setup[cmd_ep]))
        && (st_q.ovwr[$past(cmd_ep)] == $past(st_q.ovwr[cmd_ep])))
    else $error("Select-with-clear touched the flags of a non-control endpoint.");

endmodule : uess_endpoint_select_status
`default_nettype wire

// ---- dv/uess_host_model.sv ----
/*
  Bus-side traffic source that raises packet event pulses for one endpoint.
  Assumes the testbench calls send() and that events are sampled on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module uess_host_model
(
  input  wire logic       clk_sys,
  output logic            ev_ack_rx,
  output logic            ev_ack_rx_setup,
  output logic            ev_setup_overwrite,
  output logic            ev_nak_sent,
  output logic            ev_in_acked,
  output logic      [3:0] ev_ep
);
  initial
  begin
    {ev_ack_rx, ev_ack_rx_setup, ev_setup_overwrite, ev_nak_sent, ev_in_acked} = 5'h0;
    ev_ep = 4'hf;
  end
  // Pulses last one cycle; afterwards the endpoint lines show the inverse so no stale match.
  task automatic send(input logic [4:0] k, input logic [3:0] ep);
    @(posedge clk_sys);
    #2 {ev_ack_rx, ev_ack_rx_setup, ev_setup_overwrite, ev_nak_sent, ev_in_acked} = k;
    ev_ep = ep;
    @(posedge clk_sys);
    #2 {ev_ack_rx, ev_ack_rx_setup, ev_setup_overwrite, ev_nak_sent, ev_in_acked} = 5'h0;
    ev_ep = ~ep;
  endtask : send
endmodule : uess_host_model
`default_nettype wire

// ---- dv/usb_endpoint_select_status_tb.sv ----
/*
  Self-checking bench for the endpoint select and status block.
  Assumes the host model in the same folder and the package constants.
*/
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_select_status_tb;
  logic        clk_sys, reset_n, cmd_valid, data_rd, data_out_valid, buf_ptr_load;
  logic [7:0]  cmd_code, data_out;
  logic [8:0]  buf_ptr;
  logic [9:0]  ep_int_clear, ep_is_in, ep_is_control, ep_double_buf, ep_halted, b1, b2, nak_en;
  logic [89:0] ep_buf_base;
  logic        ev_ack_rx, ev_ack_rx_setup, ev_setup_overwrite, ev_nak_sent, ev_in_acked;
  logic [3:0]  ev_ep;
  int          bad_count = 0;
  int          n_tests = 0;
  localparam logic [63:0] BAD_CODES = 64'h0a0f_103f_4849_80ff;
  uess_endpoint_select_status dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .data_rd(data_rd), .data_out(data_out),
    .data_out_valid(data_out_valid), .buf_ptr(buf_ptr), .buf_ptr_load(buf_ptr_load),
    .ep_int_clear(ep_int_clear), .ep_buf_base(ep_buf_base), .ep_is_in(ep_is_in),
    .ep_is_control(ep_is_control), .ep_double_buf(ep_double_buf), .ep_halted(ep_halted),
    .ep_buf1_full(b1), .ep_buf2_full(b2), .ep_nak_int_en(nak_en), .ev_ack_rx(ev_ack_rx),
    .ev_ack_rx_setup(ev_ack_rx_setup), .ev_setup_overwrite(ev_setup_overwrite),
    .ev_nak_sent(ev_nak_sent), .ev_in_acked(ev_in_acked), .ev_ep(ev_ep));
  uess_host_model hm_u (.clk_sys(clk_sys), .ev_ack_rx(ev_ack_rx),
    .ev_ack_rx_setup(ev_ack_rx_setup), .ev_setup_overwrite(ev_setup_overwrite),
    .ev_nak_sent(ev_nak_sent), .ev_in_acked(ev_in_acked), .ev_ep(ev_ep));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  function automatic logic [7:0] exp_st(input int n, input logic [2:0] f);
    logic occ;
    occ = !ep_double_buf[n] ? b1[n] : ep_is_in[n] ? (b1[n] & b2[n]) : (b1[n] | b2[n]);
    return {1'b0, b2[n], b1[n], f, ep_halted[n], occ};
  endfunction : exp_st
  // Every command is followed by the status read, which select-with-clear demands.
  task automatic sel(input logic [7:0] code, input logic [9:0] clr, input logic [7:0] exp);
    int n;
    n = int'(code[3:0]);
    @(posedge clk_sys);
    #2 cmd_valid = 1;
    cmd_code = code;
    @(posedge clk_sys);
    #2 cmd_valid = 0;
    chk(data_out_valid, 1);
    chk(data_out, exp);
    chk(buf_ptr, ep_buf_base[n*9 +: 9]);
    chk(buf_ptr_load, 1);
    chk(ep_int_clear, clr);
    @(posedge clk_sys);
    #2 data_rd = 1;
    @(posedge clk_sys);
    #2 data_rd = 0;
    chk(data_out_valid, 0);
  endtask : sel
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial
  begin
    #200us;
    bad_count++;
    finish_test();
  end
  initial
  begin
    {reset_n, cmd_valid, data_rd, cmd_code} = 11'h0;
    {ep_is_in, ep_double_buf, ep_halted} = {10'h155, 10'h0f0, 10'h222};
    {b1, b2, ep_is_control, nak_en} = {10'h3c3, 10'h2a9, 10'h008, 10'h009};
    for (int i = 0; i < 10; i++) ep_buf_base[i*9 +: 9] = 9'(i*16 + 3);
    repeat (20) @(posedge clk_sys);
    #2 reset_n = 1;
    chk({data_out_valid, buf_ptr_load, ep_int_clear}, 0);
    for (int n = 0; n < 10; n++) sel(8'(n), 10'h0, exp_st(n, 3'b000));
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk_sys);
      #2 cmd_valid = 1;
      cmd_code = BAD_CODES[i*8 +: 8];
      @(posedge clk_sys);
      #2 cmd_valid = 0;
      chk({buf_ptr_load, ep_int_clear, data_out_valid}, 0);
      chk(buf_ptr, ep_buf_base[81 +: 9]);
      chk(data_out, exp_st(9, 3'b000));
    end
    for (int n = 0; n < 8; n++) sel(8'h40 + 8'(n), 10'h001 << n, exp_st(n, 3'b000));
    hm_u.send(5'b11000, 4'h3);
    hm_u.send(5'b00100, 4'h3);
    hm_u.send(5'b00010, 4'h3);
    hm_u.send(5'b00010, 4'h5);
    sel(8'h03, 10'h0, exp_st(3, 3'b111));
    sel(8'h05, 10'h0, exp_st(5, 3'b000));
    sel(8'h43, 10'h008, exp_st(3, 3'b111));
    sel(8'h03, 10'h0, exp_st(3, 3'b100));
    hm_u.send(5'b10000, 4'h3);
    sel(8'h03, 10'h0, exp_st(3, 3'b000));
    hm_u.send(5'b00010, 4'h0);
    sel(8'h40, 10'h001, exp_st(0, 3'b100));
    hm_u.send(5'b00001, 4'h0);
    sel(8'h00, 10'h0, exp_st(0, 3'b000));
    hm_u.send(5'b11000, 4'h1);
    sel(8'h41, 10'h002, exp_st(1, 3'b001));
    sel(8'h01, 10'h000, exp_st(1, 3'b001));
    @(posedge clk_sys);
    #2 reset_n = 0;
    repeat (2) @(posedge clk_sys);
    #2 reset_n = 1;
    chk({data_out_valid, buf_ptr_load, ep_int_clear}, 0);
    chk(buf_ptr, 0);
    sel(8'h01, 10'h000, exp_st(1, 3'b000));
    finish_test();
  end
endmodule : usb_endpoint_select_status_tb
`default_nettype wire
